// ===== hw/rrse_exec.sv
// Execution unit for rotate, return and subtract instructions with an Avalon-MM register port
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rrse_exec
  import rrse_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic      [15:0] mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic      [7:0]  mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i,
  output logic             busy_o
);

  // Effective address shared by every memory form
  function automatic logic [15:0] eff_addr(input logic [1:0] mode, input logic [7:0] hi,
                                           input logic [7:0] lo, input logic [15:0] ix);
    logic [15:0] a;
    a = {hi, lo};
    if (mode == 2'b01) begin
      a = {8'h00, lo};
    end else if (mode == 2'b10) begin
      a = ix + {8'h00, lo};
    end
    return a;
  endfunction

  rrse_state_e state;
  logic [3:0]  step;
  logic [7:0]  op;
  logic [7:0]  arg_hi;
  logic [7:0]  arg_lo;
  logic [7:0]  first_accumulator;
  logic [7:0]  second_accumulator;
  logic [7:0]  index_high_byte;
  logic [7:0]  index_low_byte;
  logic [7:0]  program_counter_high;
  logic [7:0]  program_counter_low;
  logic [15:0] stack_ptr;
  logic [7:0]  condition_code_register;
  logic [7:0]  opnd;
  logic [2:0]  rd_tag;
  logic        illegal;

  // Decode
  wire logic       is_rol   = (op[3:0] == RRSE_LO_ROL) && (op[7:6] == 2'b01);
  wire logic       is_ror   = (op[3:0] == RRSE_LO_ROR) && (op[7:6] == 2'b01);
  wire logic       is_rot   = is_rol | is_ror;
  wire logic       rot_mem  = is_rot & op[5];
  wire logic       is_sbc   = (op[3:0] == RRSE_LO_SBC) && op[7];
  wire logic       sbc_mem  = is_sbc & (op[5:4] != 2'b00);
  wire logic       is_sba   = (op == RRSE_OP_SBA);
  wire logic       is_rti   = (op == RRSE_OP_RTI);
  wire logic       is_rts   = (op == RRSE_OP_RTS);
  wire logic       sel_b    = is_sbc ? op[6] : op[4];
  wire logic [1:0] rot_mode = op[4] ? 2'b11 : 2'b10;
  wire logic [1:0] mem_mode = is_sbc ? op[5:4] : rot_mode;
  wire logic [15:0] ea      = eff_addr(mem_mode, arg_hi, arg_lo, {index_high_byte, index_low_byte});

  wire logic [3:0] sbc_cyc  = (op[5:4] == 2'b00) ? RRSE_CYC_ACC :
                              (op[5:4] == 2'b01) ? RRSE_CYC_DIR : RRSE_CYC_EXT;
  wire logic [3:0] cyc      = rot_mem ? RRSE_CYC_ROT_MEM :
                              is_rti  ? RRSE_CYC_RTI :
                              is_rts  ? RRSE_CYC_RTS :
                              is_sbc  ? sbc_cyc : RRSE_CYC_ACC;
  wire logic       legal    = is_rot | is_sbc | is_sba | is_rti | is_rts;
  wire logic       last     = (step == cyc - 4'h1);

  // Sequencing of memory cycles
  wire logic issue_pull = (is_rti && step >= 4'h1 && step <= RRSE_STEP_PULL_LAST_RTI) ||
                          (is_rts && step >= 4'h1 && step <= RRSE_STEP_PULL_LAST_RTS);
  wire logic issue_rd   = (rot_mem && step == RRSE_STEP_RD) ||
                          (sbc_mem && step == cyc - 4'h2);
  wire logic issue_wr   = rot_mem && (step == RRSE_STEP_WR);
  wire logic [2:0] pull_tag = is_rti ? step[2:0] - 3'h1 : step[2:0] + 3'h4;
  wire logic [15:0] sp_inc  = stack_ptr + 16'h0001;

  // Arithmetic
  wire logic [7:0] acc_sel  = sel_b ? second_accumulator : first_accumulator;
  wire logic [7:0] rot_src  = rot_mem ? opnd : acc_sel;
  wire logic       c_old    = condition_code_register[RRSE_CC_C];
  wire logic [7:0] rol_res  = {rot_src[6:0], c_old};
  wire logic [7:0] ror_res  = {c_old, rot_src[7:1]};
  wire logic       rot_c    = is_rol ? rot_src[7] : rot_src[0];
  wire logic [7:0] sub_x    = is_sba ? first_accumulator : acc_sel;
  wire logic [7:0] sub_m    = is_sba ? second_accumulator : (sbc_mem ? mem_rdata_i : arg_lo);
  wire logic [7:0] sub_res  = sub_x - sub_m - {7'h00, is_sbc & c_old};
  wire logic       x7       = sub_x[7];
  wire logic       m7       = sub_m[7];
  wire logic       r7s      = sub_res[7];
  wire logic       sub_c    = (~x7 & m7) | (m7 & r7s) | (r7s & ~x7);
  wire logic       sba_v    = (x7 & ~m7 & ~r7s) | (~x7 & m7 & r7s);
  wire logic       sbc_v    = (x7 & ~m7 & r7s) | (~x7 & m7 & r7s);
  wire logic [7:0] res      = is_rol ? rol_res : (is_ror ? ror_res : sub_res);
  wire logic       res_c    = is_rot ? rot_c : sub_c;
  wire logic       res_v    = is_rot ? (res[7] ^ rot_c) : (is_sba ? sba_v : sbc_v);
  wire logic       commit   = (state == RRSE_RUN) &&
                              ((last && !rot_mem && !is_rti && !is_rts) || issue_wr);
  // H and I keep their values; only N, Z, V, C move
  wire logic [7:0] cc_arith = {condition_code_register[7:4], res[7], (res == 8'h00), res_v, res_c};

  // Register port
  wire logic        req      = avs_read_i | avs_write_i;
  wire logic        blocked  = avs_write_i && (state == RRSE_RUN);  // Writes wait out a running instruction
  wire logic        wr_take  = avs_write_i && !avs_waitrequest_o;
  wire logic        start    = wr_take && (avs_address_i == RRSE_REG_CMD);
  wire logic [31:0] rd_mux   =
    (avs_address_i == RRSE_REG_ACC)  ? {16'h0000, second_accumulator, first_accumulator} :
    (avs_address_i == RRSE_REG_IDX)  ? {16'h0000, index_high_byte, index_low_byte} :
    (avs_address_i == RRSE_REG_PC)   ? {16'h0000, program_counter_high, program_counter_low} :
    (avs_address_i == RRSE_REG_SP)   ? {16'h0000, stack_ptr} :
    (avs_address_i == RRSE_REG_CCR)  ? {24'h00_0000, condition_code_register} :
    (avs_address_i == RRSE_REG_CMD)  ? {8'h00, arg_hi, arg_lo, op} :
    (avs_address_i == RRSE_REG_STAT) ? {30'h0000_0000, illegal, state == RRSE_RUN} : 32'h0000_0000;
  wire logic        wr_acc   = wr_take && (avs_address_i == RRSE_REG_ACC);
  wire logic        wr_idx   = wr_take && (avs_address_i == RRSE_REG_IDX);
  wire logic        wr_pc    = wr_take && (avs_address_i == RRSE_REG_PC);
  wire logic        wr_sp    = wr_take && (avs_address_i == RRSE_REG_SP);
  wire logic        wr_cc    = wr_take && (avs_address_i == RRSE_REG_CCR);
  wire logic        pulled   = mem_rd_o && (state == RRSE_RUN);

  // Bus handshake: one wait cycle, more for a write blocked by a running instruction, then a single-cycle acknowledge
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= !(avs_waitrequest_o && req && !blocked);
      if (avs_waitrequest_o && avs_read_i) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  // Sequencer
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state   <= RRSE_IDLE;
      step    <= 4'h0;
      op      <= 8'h00;
      arg_hi  <= 8'h00;
      arg_lo  <= 8'h00;
      illegal <= 1'b0;
      busy_o  <= 1'b0;
    end else if (state == RRSE_IDLE) begin
      step <= 4'h0;
      if (start) begin
        op      <= avs_writedata_i[7:0];
        arg_lo  <= avs_writedata_i[15:8];
        arg_hi  <= avs_writedata_i[23:16];
        state   <= RRSE_RUN;
        busy_o  <= 1'b1;
        illegal <= 1'b0;
      end
    end else if (!legal) begin
      // Unknown opcodes end at once and leave state untouched
      state   <= RRSE_IDLE;
      busy_o  <= 1'b0;
      illegal <= 1'b1;
    end else if (last) begin
      state  <= RRSE_IDLE;
      busy_o <= 1'b0;
    end else begin
      step <= step + 4'h1;
    end
  end

  // Memory port
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_addr_o  <= 16'h0000;
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_wdata_o <= 8'h00;
      rd_tag      <= RRSE_TAG_CC;
    end else begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      if (state == RRSE_RUN && legal) begin
        if (issue_pull) begin
          mem_addr_o <= sp_inc;
          mem_rd_o   <= 1'b1;
          rd_tag     <= pull_tag;
        end else if (issue_rd) begin
          mem_addr_o <= ea;
          mem_rd_o   <= 1'b1;
          rd_tag     <= RRSE_TAG_OPND;
        end else if (issue_wr) begin
          mem_addr_o  <= ea;
          mem_wr_o    <= 1'b1;
          mem_wdata_o <= res;
        end
      end
    end
  end

  // Stack pointer rises before each pull
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stack_ptr <= RRSE_SP_RESET;
    end else if (wr_sp) begin
      stack_ptr <= avs_writedata_i[15:0];
    end else if (state == RRSE_RUN && legal && issue_pull) begin
      stack_ptr <= sp_inc;
    end
  end

  // Operand latch for read-modify-write
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opnd <= 8'h00;
    end else if (pulled && rd_tag == RRSE_TAG_OPND) begin
      opnd <= mem_rdata_i;
    end
  end

  // Accumulators
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_accumulator  <= 8'h00;
      second_accumulator <= 8'h00;
    end else if (wr_acc) begin
      first_accumulator  <= avs_writedata_i[7:0];
      second_accumulator <= avs_writedata_i[15:8];
    end else if (pulled && rd_tag == RRSE_TAG_A) begin
      first_accumulator <= mem_rdata_i;
    end else if (pulled && rd_tag == RRSE_TAG_B) begin
      second_accumulator <= mem_rdata_i;
    end else if (commit && !rot_mem) begin
      // Subtract B from A never writes B
      if (sel_b && !is_sba) begin
        second_accumulator <= res;
      end else begin
        first_accumulator <= res;
      end
    end
  end

  // Index and program counter
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      index_high_byte      <= 8'h00;
      index_low_byte       <= 8'h00;
      program_counter_high <= 8'h00;
      program_counter_low  <= 8'h00;
    end else begin
      if (wr_idx) begin
        index_high_byte <= avs_writedata_i[15:8];
        index_low_byte  <= avs_writedata_i[7:0];
      end else if (pulled && rd_tag == RRSE_TAG_IXH) begin
        index_high_byte <= mem_rdata_i;
      end else if (pulled && rd_tag == RRSE_TAG_IXL) begin
        index_low_byte <= mem_rdata_i;
      end
      if (wr_pc) begin
        program_counter_high <= avs_writedata_i[15:8];
        program_counter_low  <= avs_writedata_i[7:0];
      end else if (pulled && rd_tag == RRSE_TAG_PCH) begin
        program_counter_high <= mem_rdata_i;
      end else if (pulled && rd_tag == RRSE_TAG_PCL) begin
        program_counter_low <= mem_rdata_i;
      end
    end
  end

  // Condition codes; a return from subroutine never reaches here
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      condition_code_register <= RRSE_CC_RESET;
    end else if (wr_cc) begin
      condition_code_register <= avs_writedata_i[7:0] | RRSE_CC_ONES;
    end else if (pulled && rd_tag == RRSE_TAG_CC) begin
      // Stacked I copied as is, so I clears only when it was stacked as zero
      condition_code_register <= mem_rdata_i | RRSE_CC_ONES;
    end else if (commit) begin
      condition_code_register <= cc_arith;
    end
  end

endmodule
`default_nettype wire

// ===== hw/rrse_pkg.sv
// Constants shared by the rotate, return and subtract execution block
// Summary of operation
// - Rotate-left: N from result bit 7, C from old bit 7, V = N xor C.
// - Rotate-right: shift toward bit 0, old C into bit 7, old bit 0 into C.
// - Rotate-right: V = N xor C after rotation; 2 or 6 cycles.
// - Rotates and subtracts set N and Z from result; H and I untouched.
// - Return-from-interrupt, 10 cycles, pulls seven bytes with pre-incremented stack pointer.
// - Return-from-interrupt restores all flags; I cleared only if stacked I is zero.
// - Return-from-subroutine, 5 cycles, pulls program counter high then low; flags untouched.
// - Subtract B from A, 2 cycles, result into A, B untouched.
// - Subtract B from A overflow: A7 !B7 !R7 or !A7 B7 R7.
// - Subtract B from A borrow: !A7 B7 or B7 R7 or R7 !A7.
// - Subtract with borrow carry: !X7 M7 or M7 R7 or R7 !X7.
// - Subtract with borrow overflow: X7 !M7 R7 or !X7 M7 R7.
package rrse_pkg;
  // Opcodes
  localparam logic [7:0] RRSE_OP_RTI      = 8'h3B;
  localparam logic [7:0] RRSE_OP_RTS      = 8'h39;
  localparam logic [7:0] RRSE_OP_SBA      = 8'h10;
  localparam logic [3:0] RRSE_LO_ROL      = 4'h9;
  localparam logic [3:0] RRSE_LO_ROR      = 4'h6;
  localparam logic [3:0] RRSE_LO_SBC      = 4'h2;
  // Cycle counts
  localparam logic [3:0] RRSE_CYC_ACC     = 4'h2;
  localparam logic [3:0] RRSE_CYC_ROT_MEM = 4'h6;
  localparam logic [3:0] RRSE_CYC_RTI     = 4'hA;
  localparam logic [3:0] RRSE_CYC_RTS     = 4'h5;
  localparam logic [3:0] RRSE_CYC_DIR     = 4'h3;
  localparam logic [3:0] RRSE_CYC_EXT     = 4'h4;
  // Steps inside an instruction
  localparam logic [3:0] RRSE_STEP_RD     = 4'h2;
  localparam logic [3:0] RRSE_STEP_WR     = 4'h4;
  localparam logic [3:0] RRSE_STEP_PULL_LAST_RTI = 4'h7;
  localparam logic [3:0] RRSE_STEP_PULL_LAST_RTS = 4'h2;
  // Condition code bit positions
  localparam int RRSE_CC_C = 0;
  localparam int RRSE_CC_V = 1;
  localparam int RRSE_CC_Z = 2;
  localparam int RRSE_CC_N = 3;
  localparam int RRSE_CC_I = 4;
  localparam logic [7:0] RRSE_CC_ONES     = 8'hC0;
  localparam logic [7:0] RRSE_CC_RESET    = 8'hD0;
  // Read tags: stack pulls in stack order, then the operand read
  localparam logic [2:0] RRSE_TAG_CC      = 3'h0;
  localparam logic [2:0] RRSE_TAG_B       = 3'h1;
  localparam logic [2:0] RRSE_TAG_A       = 3'h2;
  localparam logic [2:0] RRSE_TAG_IXH     = 3'h3;
  localparam logic [2:0] RRSE_TAG_IXL     = 3'h4;
  localparam logic [2:0] RRSE_TAG_PCH     = 3'h5;
  localparam logic [2:0] RRSE_TAG_PCL     = 3'h6;
  localparam logic [2:0] RRSE_TAG_OPND    = 3'h7;
  // Register word indexes (byte address is four times these)
  localparam logic [3:0] RRSE_REG_ACC     = 4'h0;
  localparam logic [3:0] RRSE_REG_IDX     = 4'h1;
  localparam logic [3:0] RRSE_REG_PC      = 4'h2;
  localparam logic [3:0] RRSE_REG_SP      = 4'h3;
  localparam logic [3:0] RRSE_REG_CCR     = 4'h4;
  localparam logic [3:0] RRSE_REG_CMD     = 4'h5;
  localparam logic [3:0] RRSE_REG_STAT    = 4'h6;
  localparam logic [15:0] RRSE_SP_RESET   = 16'h0000;
  typedef enum logic {RRSE_IDLE, RRSE_RUN} rrse_state_e;
endpackage

// ===== verification/rrse_exec_assertions.sv
// Concurrent checks on the ports of the rotate, return and subtract execution unit
`timescale 1ns/1ps
`default_nettype none
module rrse_exec_assertions
  import rrse_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic [7:0]  mem_rdata_i,
  input wire logic        busy_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // Command accepted on this edge and its opcode
  wire logic       go      = avs_write_i && !avs_waitrequest_o && (avs_address_i == RRSE_REG_CMD);
  wire logic [7:0] op      = avs_writedata_i[7:0];
  wire logic       rot_mem = go && (op[7:4] inside {4'h6, 4'h7}) && (op[3:0] inside {RRSE_LO_ROL, RRSE_LO_ROR});
  wire logic       two_cyc = go && (op inside {8'h49, 8'h59, 8'h46, 8'h56, RRSE_OP_SBA, 8'h82, 8'hC2});
  sequence s_start;
    ##1 busy_o;
  endsequence
  // Last busy cycle has no memory read, then busy drops
  sequence s_tail;
    (busy_o && !mem_rd_o) ##1 !busy_o;
  endsequence
  a_rti_pull_seq: assert property (go && op == RRSE_OP_RTI |-> s_start ##2 mem_rd_o [*7] ##1 s_tail)
    else $error("return from interrupt pull sequence wrong");
  a_rts_pull_seq: assert property (go && op == RRSE_OP_RTS |-> s_start ##2 mem_rd_o [*2] ##1 s_tail)
    else $error("return from subroutine pull sequence wrong");
  a_rot_mem_rmw: assert property (rot_mem |-> s_start ##3 (mem_rd_o && !mem_wr_o)
    ##2 (mem_wr_o && mem_addr_o == $past(mem_addr_o, 2)) ##1 !busy_o) else $error("memory rotate timing wrong");
  a_acc_two_cyc: assert property (two_cyc |-> s_start ##1 s_tail)
    else $error("two cycle instruction length wrong");
  a_pull_addr_step: assert property (mem_rd_o && $past(mem_rd_o) |-> mem_addr_o == $past(mem_addr_o) + 16'h0001)
    else $error("stack pull address not incremented");
  a_wr_one_pulse: assert property (mem_wr_o |=> !mem_wr_o && !busy_o)
    else $error("memory write not the last step");
  a_mem_quiet_idle: assert property (!busy_o |-> !mem_rd_o && !mem_wr_o)
    else $error("memory access while idle");
  a_ack_one_cyc: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("acknowledge longer than one cycle");
  a_read_no_wait: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("read not answered next cycle");
  a_write_busy_stall: assert property (avs_write_i && busy_o |=> avs_waitrequest_o)
    else $error("write accepted while busy");
  a_rdata_holds: assert property ($changed(avs_readdata_o) |-> avs_read_i && !avs_waitrequest_o)
    else $error("read data changed outside a read answer");
endmodule
`default_nettype wire

// ===== verification/rrse_mem_model.sv
// Behavioural program and stack memory on the core bus
`timescale 1ns/1ps
`default_nettype none
module rrse_mem_model (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [7:0]  mem_wdata_i,
  output logic      [7:0]  mem_rdata_o
);
  logic [7:0] store [0:65535];
  logic [7:0] last_q = 8'h00;
  // Outside a read the bus shows the inverse of the last byte, so stale data never passes
  assign mem_rdata_o = mem_rd_i ? store[mem_addr_i] : ~last_q;
  always @(posedge clk_sys_i) begin
    if (mem_rd_i) last_q <= store[mem_addr_i];
    if (mem_wr_i) store[mem_addr_i] <= mem_wdata_i;
  end
endmodule
`default_nettype wire

// ===== verification/test_rotate_return_subtract_exec.sv
// Self-checking bench for the rotate, return and subtract execution unit
`timescale 1ns/1ps
`default_nettype none
module test_rotate_return_subtract_exec;
  import rrse_pkg::*;
  logic        clk_sys_i       = 1'b0;
  logic        rst_b_i         = 1'b0;
  logic [3:0]  avs_address_i   = 4'h0;
  logic        avs_read_i      = 1'b0;
  logic        avs_write_i     = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [15:0] mem_addr_o;
  logic        mem_rd_o;
  logic        mem_wr_o;
  logic [7:0]  mem_wdata_o;
  logic [7:0]  mem_rdata_i;
  logic        busy_o;
  logic        busy_q          = 1'b0;
  logic [7:0]  busy_len        = 8'h00;
  int          error_cnt       = 0;
  int          total_checks    = 0;
  rrse_exec dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .busy_o(busy_o));
  rrse_mem_model mem (.clk_sys_i(clk_sys_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // Length of the last busy stretch, in clock cycles
  always @(posedge clk_sys_i) begin
    busy_q   <= busy_o;
    busy_len <= (busy_o && !busy_q) ? 8'h01 : busy_len + {7'h00, busy_o};
  end
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer; the request is held until waitrequest is sampled low
  task automatic bus(input logic wr_en, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr_en;
    avs_read_i      <= !wr_en;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (n >= 40) begin
      chk(32'h0000_0001, 32'h0000_0000);
      conclude();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  task automatic reset_case();
    rd(RRSE_REG_CCR, 32'h0000_00D0);
    rd(RRSE_REG_SP, 32'h0000_0000);
    rd(RRSE_REG_ACC, 32'h0000_0000);
    rd(4'hF, 32'h0000_0000);
  endtask
  // Loads operands, runs one command with a stalled write behind it, checks length and results
  task automatic run(input logic [15:0] acc, input logic [7:0] ccr, input logic [23:0] cmd, input logic [15:0] xacc,
                     input logic [7:0] xccr, input logic [7:0] cyc);
    int n;
    n = 0;
    wr(RRSE_REG_ACC, {16'h0000, acc});
    wr(RRSE_REG_CCR, {24'h00_0000, ccr});
    wr(RRSE_REG_CMD, {8'h00, cmd});
    wr(4'hF, 32'h0000_0000);
    while (busy_o !== 1'b0 && n < 40) begin
      @(posedge clk_sys_i);
      n++;
    end
    // A command that never finishes ends the run as a failure
    if (n >= 40) begin
      chk(32'h0000_0001, 32'h0000_0000);
      conclude();
    end
    chk({24'h00_0000, busy_len}, {24'h00_0000, cyc});
    rd(RRSE_REG_ACC, {16'h0000, xacc});
    rd(RRSE_REG_CCR, {24'h00_0000, xccr});
  endtask
  task automatic mem_case(input logic [15:0] ea, input logic [7:0] mv, input logic [7:0] xm, input logic [15:0] acc,
                          input logic [7:0] ccr, input logic [23:0] cmd, input logic [15:0] xacc, input logic [7:0] xccr,
                          input logic [7:0] cyc);
    mem.store[ea] = mv;
    run(acc, ccr, cmd, xacc, xccr, cyc);
    chk({24'h00_0000, mem.store[ea]}, {24'h00_0000, xm});
  endtask
  task automatic rti_case();
    logic [55:0] stk;
    stk = 56'h05_AA55_1234_5678;
    for (int i = 0; i < 7; i++) begin
      mem.store[16'h0101 + 16'(i)] = stk[55 - 8 * i -: 8];
    end
    wr(RRSE_REG_SP, 32'h0000_0100);
    run(16'h0000, 8'h10, 24'h00_003B, 16'hAA55, 8'hC5, 8'h0A);
    rd(RRSE_REG_IDX, 32'h0000_1234);
    rd(RRSE_REG_PC, 32'h0000_5678);
    rd(RRSE_REG_SP, 32'h0000_0107);
  endtask
  task automatic rts_case();
    mem.store[16'h0201] = 8'h10;
    mem.store[16'h0202] = 8'h02;
    wr(RRSE_REG_SP, 32'h0000_0200);
    run(16'h0000, 8'h2B, 24'h00_0039, 16'h0000, 8'hEB, 8'h05);
    rd(RRSE_REG_PC, 32'h0000_1002);
    rd(RRSE_REG_SP, 32'h0000_0202);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    reset_case();
    wr(RRSE_REG_IDX, 32'h0000_1000);
    run(16'h0081, 8'h30, 24'h00_0049, 16'h0002, 8'hF3, 8'h02);
    run(16'h4000, 8'h01, 24'h00_0059, 16'h8100, 8'hCA, 8'h02);
    run(16'h0001, 8'h00, 24'h00_0046, 16'h0000, 8'hC7, 8'h02);
    run(16'h0100, 8'h21, 24'h00_0056, 16'h8000, 8'hE9, 8'h02);
    run(16'h0180, 8'h11, 24'h00_0010, 16'h017F, 8'hD2, 8'h02);
    run(16'h0201, 8'h20, 24'h00_0010, 16'h02FF, 8'hE9, 8'h02);
    run(16'h3310, 8'h01, 24'h00_0582, 16'h330A, 8'hC0, 8'h02);
    run(16'h0000, 8'h00, 24'h00_8082, 16'h0080, 8'hCB, 8'h02);
    run(16'h0000, 8'h01, 24'h00_00C2, 16'hFF00, 8'hC9, 8'h02);
    mem_case(16'h1234, 8'h80, 8'h00, 16'h5566, 8'h00, 24'h12_3479, 16'h5566, 8'hC7, 8'h06);
    mem_case(16'h1034, 8'h02, 8'h81, 16'h0000, 8'h01, 24'h00_3466, 16'h0000, 8'hCA, 8'h06);
    mem_case(16'h0020, 8'h01, 8'h01, 16'h0003, 8'h01, 24'h00_2092, 16'h0001, 8'hC0, 8'h03);
    mem_case(16'h2000, 8'h20, 8'h20, 16'h1000, 8'h00, 24'h20_00F2, 16'hF000, 8'hC9, 8'h04);
    mem_case(16'h1010, 8'h7F, 8'h7F, 16'h8000, 8'h00, 24'h00_10E2, 16'h0100, 8'hC0, 8'h04);
    run(16'h0000, 8'h00, 24'h00_0001, 16'h0000, 8'hC0, 8'h01);
    rd(RRSE_REG_STAT, 32'h0000_0002);
    rti_case();
    rd(RRSE_REG_STAT, 32'h0000_0000);
    rts_case();
    conclude();
  end
endmodule
bind rrse_exec rrse_exec_assertions u_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .mem_addr_o(mem_addr_o),
  .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .busy_o(busy_o));
`default_nettype wire
